// ### two_wire_pkg.sv
/*
 * Shared constants for the two-wire configuration port: bus address, timing, encodings.
 * Assumes both ends run from a 25 MHz reference clock.
 */
// Contract
// - Address 100110 plus strap bit
// - Ignore bus until start condition
// - Host sends address then direction bit
// - Acknowledge own address, else stay released
// - Stop or repeated start ends transfer
// - Host changes data only while clock low
// - Deglitch clock three cycles, latch on rise
// - Read data changes after filtered fall
// - Write: address, register address, data, stop
// - Pointer increments after each written byte
// - Read: set pointer, repeated start, read
// - Pointer increments after each read byte
// - Host drives clock; data open drain
package two_wire_pkg;
	localparam logic [5:0] ADDR_HIGH_BITS = 6'h26;   // 100110
	localparam int         CLK_PERIOD_NS  = 40;
	localparam int         FILTER_TIME_NS = 120;
	localparam int         FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         BIT_TIME_NS    = 320;
	localparam int         HALF_BIT_CYC   = BIT_TIME_NS / CLK_PERIOD_NS / 2;
	// Host quarter bit in clk: must exceed sync plus filter so the device answers before the next edge
	localparam int         QUARTER_CYC    = 8;
	localparam logic       DIR_READ       = 1'b1;
	localparam logic       DIR_WRITE      = 1'b0;
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [7:0] PTR_RESET      = 8'h00;
	localparam logic [7:0] BYTE_ONES      = 8'hFF;
endpackage

// ### two_wire_if.sv
/*
 * Two-wire bus carrier: serial clock driven by the host, open-drain data line.
 * Resolves the wired-AND level from both ends' output enables; pull-ups assumed.
 */
`timescale 1ns/1ps
interface two_wire_if;
	logic sclOut;
	logic sclOe;
	logic sdaHostOe;
	logic sdaDevOe;
	logic scl;
	logic sda;

	// Clock driven high and low by the host; on the open-drain data line a driving party only ever pulls low
	assign scl = sclOe ? sclOut : 1'b1;
	assign sda = !(sdaHostOe || sdaDevOe);

	modport host (output sclOut, output sclOe, output sdaHostOe, input scl, input sda);
	modport dev  (output sdaDevOe, input scl, input sda);
endinterface

// ### two_wire_config_slave.sv
/*
 * Device end of the two-wire configuration port. Register storage is outside:
 * writes appear as a pulse with pointer and data, reads fetch rdData at regPtr.
 * Assumes rdData is valid combinationally for regPtr within one clock.
 */
`timescale 1ns/1ps
module two_wire_config_slave
	import two_wire_pkg::*;
#(
	parameter int FILTER_LEN = FILTER_CYCLES
)(
	input  wire logic       clk,
	input  wire logic       srst,
	two_wire_if.dev         bus,
	input  wire logic       addrStrap,
	input  wire logic [7:0] rdData,
	output logic [7:0]      regPtr,
	output logic [7:0]      wrData,
	output logic            wrStrobe,
	output logic            busy
);
	typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK, S_WDATA, S_WDATA_ACK,
		S_RDATA, S_RDATA_ACK} state_type;

	logic [1:0] sclSync_q, sdaSync_q;
	logic [7:0] sclHist_q, sclHist_d;
	logic [7:0] sdaHist_q, sdaHist_d;
	logic       byteDone_q, byteDone_d;
	logic       busy_q;
	logic       sclF_q, sclF_d, sdaF_q, sdaF_d;
	state_type  st_q, st_d;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic       oe_q, oe_d;
	logic [7:0] wrData_q, wrData_d;
	logic       wrStb_q, wrStb_d;
	logic [7:0] rdShift_q, rdShift_d;
	logic       sclRise, sclFall, startCond, stopCond, sclStable;

	// Two-flop synchronisers on both pins; the first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclSync_q <= 2'h3;
			sdaSync_q <= 2'h3;
		end
		else
		begin
			sclSync_q <= {sclSync_q[0], bus.scl};
			sdaSync_q <= {sdaSync_q[0], bus.sda};
		end
	end

	// Deglitch: clock level only accepted after FILTER_LEN+1 equal samples (FILTER_LEN held in history plus the current one)
	assign sclStable = (sclHist_q[FILTER_LEN-1:0] == {FILTER_LEN{sclSync_q[1]}});
	always_comb
	begin
		sclHist_d = {sclHist_q[6:0], sclSync_q[1]};
		sclF_d    = sclStable ? sclSync_q[1] : sclF_q;
		// Data delayed as much as the clock, else a data change after a fall looks like start or stop
		sdaHist_d = {sdaHist_q[6:0], sdaSync_q[1]};
		sdaF_d    = sdaHist_q[FILTER_LEN-1];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclHist_q <= BYTE_ONES;
			sdaHist_q <= BYTE_ONES;
			sclF_q    <= 1'b1;
			sdaF_q    <= 1'b1;
		end
		else
		begin
			sclHist_q <= sclHist_d;
			sdaHist_q <= sdaHist_d;
			sclF_q    <= sclF_d;
			sdaF_q    <= sdaF_d;
		end
	end

	assign sclRise   = sclF_d && !sclF_q;
	assign sclFall   = !sclF_d && sclF_q;
	assign startCond = sclF_q && sclF_d && sdaF_q && !sdaF_d;
	assign stopCond  = sclF_q && sclF_d && !sdaF_q && sdaF_d;

	// Bit engine: samples on filtered rise, changes drive on filtered fall
	always_comb
	begin
		st_d      = st_q;
		bitCnt_d  = bitCnt_q;
		shift_d   = shift_q;
		ptr_d     = ptr_q;
		oe_d      = oe_q;
		wrData_d  = wrData_q;
		wrStb_d   = 1'b0;
		rdShift_d = rdShift_q;
		byteDone_d = byteDone_q;
		if (startCond)
		begin
			st_d       = S_ADDR;
			bitCnt_d   = 3'h0;
			oe_d       = 1'b0;
			byteDone_d = 1'b0;
		end
		else if (stopCond)
		begin
			st_d       = S_IDLE;
			oe_d       = 1'b0;
			byteDone_d = 1'b0;
		end
		else if (sclRise)
		begin
			case (st_q)
				S_ADDR, S_REG, S_WDATA:
				begin
					shift_d  = {shift_q[6:0], sdaF_q};
					bitCnt_d = bitCnt_q + 3'h1;
					// Marks a full byte so the fall right after start is not taken as one
					if (bitCnt_q == BIT_LAST)
						byteDone_d = 1'b1;
				end
				S_RDATA_ACK:
				begin
					// Host nack ends the read burst; the pointer already moved on
					if (sdaF_q)
						st_d = S_IDLE;
				end
				default:
				begin
				end
			endcase
		end
		else if (sclFall)
		begin
			case (st_q)
				S_ADDR:
				begin
					if (byteDone_q)
					begin
						byteDone_d = 1'b0;
						if (shift_q[7:1] == {ADDR_HIGH_BITS, addrStrap})
						begin
							st_d = S_ADDR_ACK;
							oe_d = 1'b1;
						end
						else
							st_d = S_IDLE;
					end
				end
				S_ADDR_ACK:
				begin
					if (shift_q[0] == DIR_READ)
					begin
						st_d      = S_RDATA;
						rdShift_d = {rdData[6:0], 1'b0};
						oe_d      = !rdData[7];
					end
					else
					begin
						st_d = S_REG;
						oe_d = 1'b0;
					end
				end
				S_REG, S_WDATA:
				begin
					if (byteDone_q)
					begin
						byteDone_d = 1'b0;
						st_d = (st_q == S_REG) ? S_REG_ACK : S_WDATA_ACK;
						oe_d = 1'b1;
						if (st_q == S_REG)
							ptr_d = shift_q;
						else
						begin
							wrData_d = shift_q;
							wrStb_d  = 1'b1;
						end
					end
				end
				S_REG_ACK:
				begin
					st_d = S_WDATA;
					oe_d = 1'b0;
				end
				S_WDATA_ACK:
				begin
					st_d  = S_WDATA;
					oe_d  = 1'b0;
					ptr_d = ptr_q + 8'h01;
				end
				S_RDATA:
				begin
					bitCnt_d = bitCnt_q + 3'h1;
					if (bitCnt_q == BIT_LAST)
					begin
						st_d  = S_RDATA_ACK;
						oe_d  = 1'b0;
						ptr_d = ptr_q + 8'h01;
					end
					else
					begin
						oe_d      = !rdShift_q[7];
						rdShift_d = {rdShift_q[6:0], 1'b0};
					end
				end
				S_RDATA_ACK:
				begin
					st_d      = S_RDATA;
					rdShift_d = {rdData[6:0], 1'b0};
					oe_d      = !rdData[7];
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q      <= S_IDLE;
			bitCnt_q  <= 3'h0;
			shift_q   <= 8'h00;
			ptr_q     <= PTR_RESET;
			oe_q      <= 1'b0;
			wrData_q  <= 8'h00;
			wrStb_q   <= 1'b0;
			rdShift_q <= 8'h00;
			byteDone_q <= 1'b0;
			busy_q    <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			bitCnt_q  <= bitCnt_d;
			shift_q   <= shift_d;
			ptr_q     <= ptr_d;
			oe_q      <= oe_d;
			wrData_q  <= wrData_d;
			wrStb_q   <= wrStb_d;
			rdShift_q <= rdShift_d;
			byteDone_q <= byteDone_d;
			busy_q    <= (st_d != S_IDLE);
		end
	end

	// Data pin only ever pulled low, never driven high
	assign bus.sdaDevOe = oe_q;
	assign regPtr       = ptr_q;
	assign wrData       = wrData_q;
	assign wrStrobe     = wrStb_q;
	assign busy         = busy_q;
endmodule

// ### two_wire_host.sv
/*
 * Host end of the two-wire port: makes the serial clock by dividing clk and
 * runs one write or one register-read transaction per request.
 * Assumes the device answers within the bit time; data changes mid clock-low.
 */
`timescale 1ns/1ps
module two_wire_host
	import two_wire_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	two_wire_if.host        bus,
	input  wire logic       req,
	input  wire logic       reqRead,
	input  wire logic       strapSel,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] reqData,
	output logic [7:0]      rspData,
	output logic            done,
	output logic            ackErr,
	output logic            ready
);
	typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} hstate_type;

	hstate_type st_q, st_d;
	logic [3:0] phase_q, phase_d;
	logic [1:0] quarter_q, quarter_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] step_q, step_d;
	logic [8:0] tx_q, tx_d;
	logic [7:0] rx_q, rx_d;
	logic       scl_q, scl_d, sdaOe_q, sdaOe_d, done_q, done_d, err_q, err_d, rd_q, rd_d;
	logic [7:0] reg_q, reg_d, dat_q, dat_d;
	logic [1:0] sdaSync_q;
	logic       ready_q;
	logic       tick;

	// Quarter-bit tick; clock is derived from clk so no second domain
	assign tick = (phase_q == 4'(QUARTER_CYC - 1));

	// Step order: 0 addr+W, 1 reg addr, 2 data or (restart) addr+R, 3 read byte
	always_comb
	begin
		st_d = st_q; phase_d = tick ? 4'h0 : phase_q + 4'h1; quarter_d = quarter_q;
		bit_d = bit_q; step_d = step_q; tx_d = tx_q; rx_d = rx_q;
		scl_d = scl_q; sdaOe_d = sdaOe_q; done_d = 1'b0; err_d = err_q;
		rd_d = rd_q; reg_d = reg_q; dat_d = dat_q;
		case (st_q)
			H_IDLE:
			begin
				phase_d = 4'h0; scl_d = 1'b1; sdaOe_d = 1'b0;
				if (req)
				begin
					st_d = H_START; rd_d = reqRead; reg_d = regAddr; dat_d = reqData;
					step_d = 2'h0; quarter_d = 2'h0; err_d = 1'b0;
				end
			end
			H_START:
			if (tick)
			begin
				quarter_d = quarter_q + 2'h1;
				case (quarter_q)
					2'h0: begin scl_d = 1'b1; sdaOe_d = 1'b0; end
					2'h1: sdaOe_d = 1'b1;
					2'h2: scl_d = 1'b0;
					default:
					begin
						st_d = H_BYTE; bit_d = 4'h0; quarter_d = 2'h0;
						tx_d = {ADDR_HIGH_BITS, strapSel, (step_q == 2'h2) ? DIR_READ : DIR_WRITE, 1'b1};
					end
				endcase
			end
			H_BYTE:
			if (tick)
			begin
				quarter_d = quarter_q + 2'h1;
				case (quarter_q)
					2'h0: sdaOe_d = !tx_q[8];
					2'h1: scl_d = 1'b1;
					2'h2: rx_d = {rx_q[6:0], sdaSync_q[1]};
					default:
					begin
						scl_d = 1'b0; tx_d = {tx_q[7:0], 1'b1}; bit_d = bit_q + 4'h1;
						if (bit_q == 4'h8)
						begin
							if (step_q != 2'h3 && rx_q[0]) err_d = 1'b1;
							bit_d = 4'h0;
							if (step_q == 2'h0)
							begin
								step_d = 2'h1; tx_d = {reg_q, 1'b1};
								if (rx_q[0]) st_d = H_STOP;
							end
							else if (step_q == 2'h1)
							begin
								step_d = 2'h2; tx_d = {dat_q, 1'b1};
								if (rd_q) begin st_d = H_START; quarter_d = 2'h0; end
							end
							else if (step_q == 2'h2 && rd_q)
							begin
								step_d = 2'h3; tx_d = {BYTE_ONES, 1'b1};
							end
							else
								st_d = H_STOP;
						end
						// Single read byte is the last one: released ack bit is the nack
						if (step_q == 2'h3 && bit_q == 4'h7) dat_d = rx_q;
					end
				endcase
			end
			H_STOP:
			if (tick)
			begin
				quarter_d = quarter_q + 2'h1;
				case (quarter_q)
					2'h0: sdaOe_d = 1'b1;
					2'h1: scl_d = 1'b1;
					2'h2: sdaOe_d = 1'b0;
					default: begin st_d = H_IDLE; done_d = 1'b1; end
				endcase
			end
			default: st_d = H_IDLE;
		endcase
	end

	// Read byte taken from the synchronised data pin
	always_ff @(posedge clk)
	begin
		if (srst)
			sdaSync_q <= 2'h3;
		else
			sdaSync_q <= {sdaSync_q[0], bus.sda};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= H_IDLE; phase_q <= 4'h0; quarter_q <= 2'h0; bit_q <= 4'h0; step_q <= 2'h0;
			tx_q <= 9'h1FF; rx_q <= 8'h00; scl_q <= 1'b1; sdaOe_q <= 1'b0; done_q <= 1'b0;
			err_q <= 1'b0; rd_q <= 1'b0; reg_q <= 8'h00; dat_q <= 8'h00;
			ready_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d; phase_q <= phase_d; quarter_q <= quarter_d; bit_q <= bit_d; step_q <= step_d;
			tx_q <= tx_d; rx_q <= rx_d;
			ready_q <= (st_d == H_IDLE);
			scl_q <= scl_d; sdaOe_q <= sdaOe_d; done_q <= done_d;
			err_q <= err_d; rd_q <= rd_d; reg_q <= reg_d; dat_q <= dat_d;
		end
	end

	assign bus.sclOut    = scl_q;
	assign bus.sclOe     = 1'b1;
	assign bus.sdaHostOe = sdaOe_q;
	assign rspData       = dat_q;
	assign done          = done_q;
	assign ackErr        = err_q;
	assign ready         = ready_q;
endmodule

// ### two_wire_sva.sv
/* Checker for the two-wire bus joining host and device ends.
   Assumes it stands beside the carrier and sees its resolved lines. */
`timescale 1ns/1ps
module two_wire_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaHostOe,
	input wire logic sdaDevOe,
	input wire logic scl,
	input wire logic sda
);
	logic sdaP_q;
	logic sclP_q;
	logic busOn_q;
	logic busOn_d;
	logic startC;
	logic stopC;

	// Framing on the raw wire; the device filters, so this leads it
	always_comb
	begin
		startC = sclP_q && scl && sdaP_q && !sda;
		stopC = sclP_q && scl && !sdaP_q && sda;
		busOn_d = startC ? 1'b1 : (stopC ? 1'b0 : busOn_q);
	end

	// Registers of the framing tracker
	always_ff @(posedge clk)
	begin
		sdaP_q <= sda;
		sclP_q <= scl;
		busOn_q <= srst ? 1'b0 : busOn_d;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_reset_lines_idle: assert property ($fell(srst) |-> scl && sda)
		else $error("lines not idle after reset");
	a_reset_dev_quiet: assert property ($fell(srst) |-> !sdaDevOe [*8])
		else $error("device drives data after reset");
	a_start_before_drive: assert property (sdaDevOe |-> busOn_q)
		else $error("device drove data outside a transfer");
	a_dev_after_fall: assert property ($changed(sdaDevOe) |-> !$past(scl, 3))
		else $error("device changed data too soon after clock fall");
	a_scl_high_width: assert property ($rose(scl) |-> scl [*3])
		else $error("clock high shorter than the filter");
	a_scl_low_width: assert property ($fell(scl) |-> !scl [*3])
		else $error("clock low shorter than the filter");
	a_host_edge_stable: assert property (($rose(scl) || $fell(scl)) |-> $stable(sdaHostOe))
		else $error("host data moved at a clock edge");
	a_stop_released: assert property (stopC |-> !sdaDevOe [*2])
		else $error("device holds data after stop");
	a_scl_from_host: assert property (sclOe |-> scl == sclOut)
		else $error("clock line not following the host");

	c_start: cover property (startC && !busOn_q);
	c_restart: cover property (startC && busOn_q);
	c_dev_ack: cover property ($rose(sdaDevOe));
	c_stop: cover property (stopC);
endmodule

// ### tb_two_wire_config_slave.sv
/* Testbench: host and device ends across one carrier, plus a second device
   driven bit by bit. Assumes a 25 MHz clock and the package timing. */
`timescale 1ns/1ps
module tb_two_wire_config_slave;
	import two_wire_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       req = 1'b0;
	logic       reqRead = 1'b0;
	logic       strapSel = 1'b0;
	logic       addrStrap = 1'b0;
	logic       scl2 = 1'b1;
	logic       sdaOe2 = 1'b0;
	logic       ack;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] reqData = 8'h00;
	logic [7:0] rspData, regPtr, wrData, rdData;
	logic       done, ackErr, ready, wrStrobe, busy;
	logic [7:0] regs [256];
	int         n_fail = 0;
	int         n_checks = 0;

	two_wire_if bus ();
	two_wire_if bus2 ();
	assign bus2.sclOe = 1'b1;
	assign bus2.sclOut = scl2;
	assign bus2.sdaHostOe = sdaOe2;

	always #20 clk = ~clk;

	two_wire_host two_wire_host_inst (.clk, .srst, .bus(bus.host), .req, .reqRead, .strapSel,
		.regAddr, .reqData, .rspData, .done, .ackErr, .ready);
	two_wire_config_slave two_wire_config_slave_inst (.clk, .srst, .bus(bus.dev), .addrStrap,
		.rdData, .regPtr, .wrData, .wrStrobe, .busy);
	// Second device with strap low, driven by hand
	two_wire_config_slave two_wire_config_slave_b_inst (.clk, .srst, .bus(bus2.dev), .addrStrap(1'b0),
		.rdData(8'h00), .regPtr(), .wrData(), .wrStrobe(), .busy());
	two_wire_sva two_wire_sva_inst (.clk, .srst, .sclOut(bus.sclOut), .sclOe(bus.sclOe),
		.sdaHostOe(bus.sdaHostOe), .sdaDevOe(bus.sdaDevOe), .scl(bus.scl), .sda(bus.sda));

	// Register storage outside the port
	assign rdData = regs[regPtr];
	always @(posedge clk)
		if (wrStrobe)
			regs[regPtr] <= wrData;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One host transaction; each wait is bounded
	task automatic xfer(input logic rd, input logic sel, input logic [7:0] a, input logic [7:0] d);
		int i;
		i = 0;
		while (ready !== 1'b1 && i < 50)
		begin
			@(negedge clk);
			i++;
		end
		if (i >= 50)
		begin
			n_fail++;
			print_verdict();
		end
		@(posedge clk);
		req <= 1'b1;
		reqRead <= rd;
		strapSel <= sel;
		regAddr <= a;
		reqData <= d;
		@(posedge clk);
		req <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 4000)
		begin
			@(negedge clk);
			i++;
		end
		if (i >= 4000)
		begin
			n_fail++;
			print_verdict();
		end
	endtask

	// Half a bit on the hand-driven bus; 8 clk so the filtered device answers within the low half
	task automatic half(input logic c, input logic low);
		@(posedge clk);
		scl2 <= c;
		repeat (3) @(posedge clk);
		sdaOe2 <= low;
		repeat (4) @(posedge clk);
	endtask

	task automatic sendByte(input logic [7:0] b, output logic a);
		for (int k = 7; k >= 0; k--)
		begin
			half(1'b0, !b[k]);
			half(1'b1, !b[k]);
		end
		half(1'b0, 1'b0);
		half(1'b1, 1'b0);
		@(negedge clk);
		a = !bus2.sda;
	endtask

	initial
	begin
		for (int k = 0; k < 256; k++)
			regs[k] = 8'(k) ^ 8'hA5;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk(regPtr, PTR_RESET);
		chk({7'h00, busy}, 8'h00);
		// Both strap settings, with the wrong low bit refused
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clk);
			addrStrap <= s[0];
			xfer(DIR_WRITE, s[0], 8'h10, 8'h5A + 8'(s));
			chk({7'h00, ackErr}, 8'h00);
			chk(regs[8'h10], 8'h5A + 8'(s));
			chk(regPtr, 8'h11);
			xfer(DIR_READ, s[0], 8'h10, 8'h00);
			chk(rspData, 8'h5A + 8'(s));
			chk(regPtr, 8'h11);
			xfer(DIR_WRITE, !s[0], 8'h20, 8'h33);
			chk({7'h00, ackErr}, 8'h01);
			chk(regs[8'h20], 8'h20 ^ 8'hA5);
		end
		// Reset in mid-run clears the pointer
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk(regPtr, PTR_RESET);
		// Pointer wraps at the top register
		xfer(DIR_WRITE, 1'b1, 8'hFF, 8'hC3);
		chk(regs[8'hFF], 8'hC3);
		chk(regPtr, 8'h00);
		// Hand-driven bus: a byte without start, then framed ones
		sendByte(8'h98, ack);
		chk({7'h00, ack}, 8'h00);
		half(1'b0, 1'b0);
		half(1'b1, 1'b1);
		sendByte(8'h4E, ack);
		chk({7'h00, ack}, 8'h00);
		half(1'b0, 1'b1);
		half(1'b1, 1'b1);
		half(1'b1, 1'b0);
		chk({7'h00, bus2.sda}, 8'h01);
		half(1'b1, 1'b1);
		sendByte(8'h98, ack);
		chk({7'h00, ack}, 8'h01);
		sendByte(8'h00, ack);
		chk({7'h00, ack}, 8'h01);
		half(1'b0, 1'b1);
		half(1'b1, 1'b1);
		half(1'b1, 1'b0);
		print_verdict();
	end
endmodule
